// *** core/pcm_pkg.sv ***
// constants, register map and state codes for the positioning completion monitor
package pcm_pkg;

  // register map (communication addresses)
  localparam logic [15:0] PCM_ADDR_BEHAVIOR = 16'h0160;
  localparam logic [15:0] PCM_ADDR_WIDTH    = 16'h016c;

  // reset values
  localparam logic [15:0] PCM_RST_BEHAVIOR  = 16'h0000;
  localparam logic [31:0] PCM_RST_WIDTH     = 32'h0000_3200;

  // completion behaviour setting fields: X in the low digit, Y in the next
  localparam int          PCM_LATCH_BIT     = 0;
  localparam int          PCM_ALARM_BIT     = 4;
  localparam logic [15:0] PCM_BEHAVIOR_MASK = 16'h0011;

  // digital output function code that selects the motion-complete flag
  localparam logic [7:0]  PCM_DO_CODE_MC    = 8'h17;

  // done_delay counts in milliseconds
  localparam int          PCM_CLK_PERIOD_NS = 5;
  localparam int          PCM_TICK_NS       = 1000000;
  localparam int          PCM_TICK_CYCLES   = PCM_TICK_NS / PCM_CLK_PERIOD_NS;
  localparam int          PCM_TICK_CNT_W    = 18;
  localparam int          PCM_DLY_W         = 16;

  // command-done sequencer states
  typedef enum logic [1:0]
  {
    PCM_DS_IDLE = 2'b00,
    PCM_DS_WAIT = 2'b01,
    PCM_DS_DONE = 2'b10
  } pcm_dstate_t;

endpackage

// *** core/pcm_done_delay.sv ***
// command-done flag with optional millisecond delay after the profile ends
`timescale 1ns/100ps
module pcm_done_delay
  import pcm_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 tick,
  input  wire logic                 cmd_start,
  input  wire logic                 profile_done,
  input  wire logic [PCM_DLY_W-1:0] done_delay,
  output logic                      cmd_done_ff
);

  pcm_dstate_t          state_ff;
  pcm_dstate_t          nxt_state;
  logic [PCM_DLY_W-1:0] cnt_ff;
  logic [PCM_DLY_W-1:0] nxt_cnt;
  wire                  delay_met = (cnt_ff >= done_delay);

  // arm on a new command, count ms ticks once the profile has been output
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      PCM_DS_IDLE:
      begin
        nxt_cnt = '0;
        if (profile_done)
          nxt_state = PCM_DS_WAIT;
      end
      PCM_DS_WAIT:
      begin
        if (delay_met)
          nxt_state = PCM_DS_DONE;
        else if (tick)
          nxt_cnt = cnt_ff + 1'b1;
      end
      PCM_DS_DONE: nxt_state = PCM_DS_DONE;
      default:     nxt_state = PCM_DS_IDLE;
    endcase
    // a new command wins over everything, flag drops at once
    if (cmd_start)
    begin
      nxt_state = PCM_DS_IDLE;
      nxt_cnt   = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_ff    <= PCM_DS_IDLE;
      cnt_ff      <= '0;
      cmd_done_ff <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      cmd_done_ff <= (nxt_state == PCM_DS_DONE);
    end
  end

endmodule

// *** core/pcm_monitor.sv ***
// positioning completion monitor: in-position, command-done, motion-complete, deviation fault
// Behaviour
// - motion-complete on output function code 0x17
// - latch 0: motion-complete follows its conditions
// - latch 1: motion-complete stays on once set
// - alarm field enables the deviation fault
// - new command clears done, in-position, complete
// - command-done after profile output plus delay
// - pulse-train: in-position when error below width
// - register mode: in-position when target-actual below width
// - latch 0: complete needs done and in-position
// - latch 1: complete set, kept after in-position drops
// - lost completion raises fault when enabled
`timescale 1ns/100ps
module pcm_monitor
  import pcm_pkg::*;
#(
  parameter int TICK_CYCLES = PCM_TICK_CYCLES
)
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [15:0]          reg_addr,
  input  wire logic                 reg_wr_en,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_rd_en,
  output logic      [31:0]          reg_rdata_ff,
  output logic                      reg_rd_valid_ff,
  input  wire logic                 internal_register_position_mode,
  input  wire logic                 cmd_start,
  input  wire logic                 profile_done,
  input  wire logic [PCM_DLY_W-1:0] done_delay,
  input  wire logic signed [31:0]   error_pulse_count,
  input  wire logic signed [31:0]   target_position,
  input  wire logic signed [31:0]   actual_position,
  input  wire logic [7:0]           do_function_select,
  input  wire logic                 fault_clear,
  output logic                      cmd_done_flag_ff,
  output logic                      in_position_flag_ff,
  output logic                      motion_complete_flag_ff,
  output logic                      position_deviation_fault_ff,
  output logic                      digital_output_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] completion_behavior_config_ff;
  logic [31:0] in_position_width_limit_ff;
  logic [31:0] nxt_rdata;

  wire hit_behavior = (reg_addr == PCM_ADDR_BEHAVIOR);
  wire hit_width    = (reg_addr == PCM_ADDR_WIDTH);
  wire latch_x      = completion_behavior_config_ff[PCM_LATCH_BIT];
  wire alarm_y      = completion_behavior_config_ff[PCM_ALARM_BIT];

  // read mux; unmapped addresses read as zero
  assign nxt_rdata = hit_behavior ? {16'h0000, completion_behavior_config_ff} :
                     hit_width    ? in_position_width_limit_ff : 32'h0000_0000;

  // only bit 0 of each of the two documented digits is kept, the rest reads zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      completion_behavior_config_ff <= PCM_RST_BEHAVIOR;
      in_position_width_limit_ff    <= PCM_RST_WIDTH;
    end
    else if (reg_wr_en)
    begin
      if (hit_behavior)
        completion_behavior_config_ff <= reg_wdata[15:0] & PCM_BEHAVIOR_MASK;
      if (hit_width)
        in_position_width_limit_ff <= reg_wdata;
    end
  end

  // read data comes one cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata_ff    <= 32'h0000_0000;
      reg_rd_valid_ff <= 1'b0;
    end
    else
    begin
      reg_rdata_ff    <= reg_rd_en ? nxt_rdata : 32'h0000_0000;
      reg_rd_valid_ff <= reg_rd_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond enable and command-done

  logic [PCM_TICK_CNT_W-1:0] tick_cnt_ff;
  logic                      tick_ff;
  logic                      cmd_done;

  // free-running divider, one-cycle enable every millisecond
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end
    else if (tick_cnt_ff == PCM_TICK_CNT_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff     <= 1'b0;
    end
  end

  pcm_done_delay pcm_done_delay_inst
  (
    .clock        (clock),
    .rst          (rst),
    .tick         (tick_ff),
    .cmd_start    (cmd_start),
    .profile_done (profile_done),
    .done_delay   (done_delay),
    .cmd_done_ff  (cmd_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // in-position, motion-complete and deviation fault

  // error source by mode; magnitude so both directions count the same
  wire signed [31:0] pos_diff  = target_position - actual_position;
  wire signed [31:0] err_sel   = internal_register_position_mode ? pos_diff
                                                                 : error_pulse_count;
  wire        [31:0] err_mag   = err_sel[31] ? 32'(-err_sel) : err_sel;
  wire               nxt_inpos = !cmd_start && (err_mag < in_position_width_limit_ff);
  wire               qualify   = cmd_done && in_position_flag_ff;

  // latched mode keeps the flag, plain mode follows both conditions
  wire nxt_mc = cmd_start ? 1'b0 :
                latch_x   ? (motion_complete_flag_ff | qualify) :
                            qualify;

  logic reached_ff;
  // completion lost after it was reached: in-position or plain flag drops
  wire lost      = reached_ff && (!in_position_flag_ff || (!latch_x && !motion_complete_flag_ff));
  wire fault_set = lost && alarm_y;
  wire nxt_fault = fault_set | (position_deviation_fault_ff & !fault_clear);
  wire nxt_dout  = (do_function_select == PCM_DO_CODE_MC) && nxt_mc;

  // a new command restarts the watch; set beats clear on the fault
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      in_position_flag_ff         <= 1'b0;
      motion_complete_flag_ff     <= 1'b0;
      reached_ff                  <= 1'b0;
      position_deviation_fault_ff <= 1'b0;
      digital_output_ff           <= 1'b0;
      cmd_done_flag_ff            <= 1'b0;
    end
    else
    begin
      in_position_flag_ff         <= nxt_inpos;
      motion_complete_flag_ff     <= nxt_mc;
      reached_ff                  <= !cmd_start && (reached_ff || motion_complete_flag_ff);
      position_deviation_fault_ff <= nxt_fault;
      digital_output_ff           <= nxt_dout;
      cmd_done_flag_ff            <= cmd_done && !cmd_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_new_cmd;
    cmd_start;
  endsequence

  sequence s_cleared;
    !in_position_flag_ff && !motion_complete_flag_ff && !cmd_done_flag_ff;
  endsequence

  AST_START_CLEARS: assert property (s_new_cmd |=> s_cleared)
    else $error("new command did not clear completion flags");

  AST_DONE_AFTER_PROFILE: assert property ($rose(cmd_done) |-> $past(profile_done))
    else $error("command done without profile output");

  AST_INPOS_WIDTH: assert property (!cmd_start
      && !internal_register_position_mode && error_pulse_count < 0
      && -error_pulse_count < $signed(in_position_width_limit_ff)
      && !reg_wr_en |=> in_position_flag_ff)
    else $error("negative error inside width not in position");

  AST_INPOS_REG: assert property (!cmd_start && internal_register_position_mode
      && err_mag >= in_position_width_limit_ff |=> !in_position_flag_ff)
    else $error("in position with difference at or above width");

  AST_PLAIN_NEEDS_BOTH: assert property (!latch_x && !cmd_start && !reg_wr_en
      |=> motion_complete_flag_ff == $past(cmd_done && in_position_flag_ff))
    else $error("plain motion complete not equal to done and in position");

  AST_LATCH_SETS: assert property (latch_x && qualify && !cmd_start
      |=> motion_complete_flag_ff [*1] ##1 (motion_complete_flag_ff || $past(cmd_start)))
    else $error("latched motion complete not set");

  AST_LATCH_HOLDS: assert property (latch_x && !reg_wr_en && motion_complete_flag_ff
      && !cmd_start |=> motion_complete_flag_ff)
    else $error("latched motion complete dropped");

  AST_NO_FAULT_Y0: assert property (!alarm_y && !position_deviation_fault_ff
      |=> !position_deviation_fault_ff)
    else $error("deviation fault raised while disabled");

  AST_FAULT_RAISE: assert property (alarm_y && reached_ff && !in_position_flag_ff
      |=> position_deviation_fault_ff)
    else $error("lost completion did not raise fault");

  AST_DO_CODE: assert property ($rose(motion_complete_flag_ff)
      && $past(do_function_select) == PCM_DO_CODE_MC |-> digital_output_ff)
    else $error("digital output missing motion complete");

endmodule

// *** dv/pcm_host_model.sv ***
// host-side stand-in that plays out the internal profile after each command
`timescale 1ns/100ps
module pcm_host_model
#(
  parameter int LEN = 3
)
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic cmd_start,
  output logic      profile_done
);
  logic [7:0] cnt_ff;

  // profile runs LEN cycles, then done holds until the next command restarts it
  always_ff @(posedge clock)
  begin
    if (rst || cmd_start)
    begin
      cnt_ff       <= 8'h00;
      profile_done <= 1'b0;
    end
    else if (cnt_ff < 8'(LEN))
      cnt_ff <= cnt_ff + 8'h01;
    else
      profile_done <= 1'b1;
  end
endmodule

// *** dv/positioning_completion_monitor_test.sv ***
// self-checking bench for the positioning completion monitor
`timescale 1ns/100ps
module positioning_completion_monitor_test
  import pcm_pkg::*;
;
  logic               clock, rst, wr, rd, mode, start_p, fclr, pdone;
  logic        [15:0] addr, dly;
  logic        [31:0] wdat, rdat;
  logic signed [31:0] perr, tgt, act;
  logic        [7:0]  dsel;
  logic               rvalid, done, ip, mc, flt, dout;
  int                 err_total, check_count, n0, n1;

  pcm_monitor #(.TICK_CYCLES(4)) pcm_monitor_inst (.clock(clock), .rst(rst), .reg_addr(addr),
    .reg_wr_en(wr), .reg_wdata(wdat), .reg_rd_en(rd), .reg_rdata_ff(rdat),
    .reg_rd_valid_ff(rvalid), .internal_register_position_mode(mode), .cmd_start(start_p),
    .profile_done(pdone), .done_delay(dly), .error_pulse_count(perr), .target_position(tgt),
    .actual_position(act), .do_function_select(dsel), .fault_clear(fclr),
    .cmd_done_flag_ff(done), .in_position_flag_ff(ip), .motion_complete_flag_ff(mc),
    .position_deviation_fault_ff(flt), .digital_output_ff(dout));
  pcm_host_model pcm_host_model_inst (.clock(clock), .rst(rst), .cmd_start(start_p),
    .profile_done(pdone));

  // 200 MHz clock
  always #2.5 clock = ~clock;

  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // packs done, in-position, complete and output into one nibble
  task automatic flags(input logic [31:0] e);
    chk({28'h0, done, ip, mc, dout}, e);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    addr = a; wdat = d; wr = 1'b1; cyc(1); wr = 1'b0;
  endtask
  // read data stands one cycle only, so it is taken at the next falling edge;
  // one idle edge follows so a second read never re-raises the strobe at once
  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
    addr = a; rd = 1'b1; cyc(1); rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdat, e);
    cyc(1);
    chk({31'h0, rvalid}, 32'h0);
  endtask
  task automatic start();
    start_p = 1'b1; cyc(1); start_p = 1'b0;
  endtask
  // bounded wait; a hang ends the run
  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b1 && n < 60)
    begin
      cyc(1); n++;
    end
    if (n == 60)
    begin
      err_total++; print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_reg(PCM_ADDR_WIDTH, PCM_RST_WIDTH);
    rd_reg(PCM_ADDR_BEHAVIOR, {16'h0000, PCM_RST_BEHAVIOR});
    wr_reg(16'h0170, 32'hFFFF_FFFF);
    rd_reg(16'h0170, 32'h0000_0000);
    wr_reg(PCM_ADDR_BEHAVIOR, 32'h0000_FFFF);
    rd_reg(PCM_ADDR_BEHAVIOR, 32'h0000_0011);
    wr_reg(PCM_ADDR_WIDTH, 32'h0000_0064);
    rd_reg(PCM_ADDR_WIDTH, 32'h0000_0064);
  endtask
  // latch off, alarm off; error one below width, then exactly at width
  task automatic t_plain();
    wr_reg(PCM_ADDR_BEHAVIOR, 32'h0000_0000); perr = -99;
    start(); wait_done(n0); cyc(2);
    flags(32'hF);
    dsel = 8'h16; cyc(2);
    flags(32'hE);
    dsel = PCM_DO_CODE_MC; perr = 100; cyc(3);
    flags(32'h8);
    chk({31'h0, flt}, 32'h0);
  endtask
  // start first: the completion lost at the end of the plain run must not
  // meet an alarm that is already enabled
  task automatic t_alarm();
    perr = 0; start();
    wr_reg(PCM_ADDR_BEHAVIOR, 32'h0000_0010);
    wait_done(n1); cyc(2);
    chk({31'h0, flt}, 32'h0);
    perr = -100; cyc(3);
    chk({31'h0, flt}, 32'h1);
  endtask
  task automatic t_latch();
    wr_reg(PCM_ADDR_BEHAVIOR, 32'h0000_0011); perr = 0;
    start(); fclr = 1'b1; cyc(1); fclr = 1'b0;
    wait_done(n1); cyc(2);
    flags(32'hF);
    perr = 100; cyc(3);
    flags(32'hB);
    chk({31'h0, flt}, 32'h1);
    start();
    flags(32'h0);
    fclr = 1'b1; cyc(1); fclr = 1'b0; cyc(1);
    chk({31'h0, flt}, 32'h0);
  endtask
  // register mode ignores the pulse error and uses target minus actual
  task automatic t_mode();
    mode = 1'b1; perr = 100000; tgt = 500; act = 401;
    start(); wait_done(n1); cyc(2);
    chk({31'h0, ip}, 32'h1);
    act = 600; cyc(2);
    chk({31'h0, ip}, 32'h0);
    mode = 1'b0;
  endtask
  // three ticks of four cycles; the first tick may come early
  task automatic t_delay();
    wr_reg(PCM_ADDR_BEHAVIOR, 32'h0000_0000); perr = 0; dly = 16'h0003;
    start(); wait_done(n1);
    chk({31'h0, n1 >= n0 + 9 && n1 <= n0 + 12}, 32'h1);
  endtask

  initial
  begin
    clock = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; mode = 1'b0; start_p = 1'b0;
    fclr = 1'b0; addr = 16'h0000; dly = 16'h0000; wdat = 32'h0000_0000; perr = 0;
    tgt = 0; act = 0; dsel = PCM_DO_CODE_MC; err_total = 0; check_count = 0;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    t_regs();
    t_plain();
    t_alarm();
    t_latch();
    t_mode();
    t_delay();
    print_verdict();
  end
endmodule
